// File: cpu_bus_cycle_sequencer.sv
// Operation
// - Indexed accumulator store: 6 cycles, three idle, then write at X+offset.
// - Read-modify-write: 7 indexed, 6 extended; read, idle, write same address.
// - Test operand: final cycle keeps strobe low, memory left unchanged.
// - Stack/index store: 7 indexed, 6 extended; high byte then low at +1.
// - Indexed call: 8 cycles; push return low at SP, high at SP-1.
// - Extended jump: 3 cycles; op code, target high, target low.
// - Extended reads: 4 cycles single byte, 5 double, high byte first.
// - Extended accumulator store: 5 cycles; idle at destination, then write.
// - Extended call: 9 cycles; read subroutine op code, push, reread low.
// - Simple inherent: 2 cycles; op code then next op code location.
// - Pull: 4 cycles; idle at SP, then read SP+1.
// - Return: 5 cycles; discard, idle at SP, read SP+1 high, SP+2 low.
// - Wait: 9 cycles stacking seven bytes from SP down to SP-6.
// - Trap: 12 cycles; stack seven bytes, idle, read vector FFFA, FFFB.
// - Interrupt return: 10 cycles reading seven bytes at SP+1 to SP+7.
// - Branches: 4 cycles; op code, offset, idle at PC+2, idle at target.
// - Branch call: 8 cycles; idle, push low then high, three idle.
// - Branch call last address: call high byte, subroutine low byte.
// - Second cycle of both returns reads PC+1 and discards the data.
`include "seq_cfg.svh"
`default_nettype none

module cpu_bus_cycle_sequencer (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	// Instruction request
	input  wire logic                  start_i,
	input  wire seq_pkg::cls_t         class_i,
	input  wire logic                  use_b_i,
	// Register file snapshot
	input  wire logic [15:0]           pc_i,
	input  wire logic [15:0]           sp_i,
	input  wire logic [15:0]           x_i,
	input  wire logic [7:0]            acc_a_i,
	input  wire logic [7:0]            acc_b_i,
	input  wire logic [7:0]            cc_i,
	input  wire logic [15:0]           word_i,
	input  wire logic [7:0]            new_i,
	// System bus
	input  wire logic [7:0]            data_i,
	output logic [15:0]                addr_o,
	output logic                       vma_o,
	output logic                       rw_o,
	output logic [7:0]                 data_o,
	output logic                       data_oe_n_o,
	// Status and results
	output logic                       busy_o,
	output logic                       done_o,
	output logic [15:0]                word_o,
	output logic [15:0]                target_o
);

	////////////////////////////////////////////////////////////////////
	// Micro-step table

	function automatic seq_pkg::micro_t rd(
		input seq_pkg::addr_src_t a,
		input logic signed [3:0]  d,
		input seq_pkg::cap_t      c,
		input logic               l
	);
		seq_pkg::micro_t m;
		m.valid_address_strobe  = 1'b1;
		m.rw   = 1'b1;
		m.asrc = a;
		m.dsp  = d;
		m.dsrc = seq_pkg::D_NONE;
		m.cap  = c;
		m.last = l;
		return m;
	endfunction

	function automatic seq_pkg::micro_t wr(
		input seq_pkg::addr_src_t a,
		input logic signed [3:0]  d,
		input seq_pkg::dat_src_t  s,
		input logic               l
	);
		seq_pkg::micro_t m;
		m = rd(a, d, seq_pkg::C_NONE, l);
		m.rw   = 1'b0;
		m.dsrc = s;
		return m;
	endfunction

	// Internal cycle: strobe low so nothing on the bus is selected
	function automatic seq_pkg::micro_t nv(
		input seq_pkg::addr_src_t a,
		input logic signed [3:0]  d,
		input logic               l
	);
		seq_pkg::micro_t m;
		m = rd(a, d, seq_pkg::C_NONE, l);
		m.valid_address_strobe = 1'b0;
		return m;
	endfunction

	function automatic seq_pkg::micro_t micro(
		input seq_pkg::cls_t c,
		input logic [3:0]    n
	);
		seq_pkg::micro_t m;
		logic            ext;
		logic            inh;
		ext = (c >= seq_pkg::CL_EXT_JUMP) && (c <= seq_pkg::CL_EXT_CALL);
		inh = (c >= seq_pkg::CL_INH) && (c <= seq_pkg::CL_IRET);
		m = nv(seq_pkg::A_PC, 4'sh0, 1'b1);
		if (n == 4'h1) begin
			m = rd(seq_pkg::A_PC, 4'sh0, seq_pkg::C_NONE, 1'b0);
		end else if (n == 4'h2) begin
			if (ext)
				m = rd(seq_pkg::A_PC1, 4'sh0, seq_pkg::C_EAHI, 1'b0);
			else if (inh)
				// Data of returns is ignored here
				m = rd(seq_pkg::A_PC1, 4'sh0, seq_pkg::C_NONE,
					c == seq_pkg::CL_INH);
			else
				m = rd(seq_pkg::A_PC1, 4'sh0, seq_pkg::C_OFF, 1'b0);
		end else if (n == 4'h3 && ext) begin
			m = rd(seq_pkg::A_PC2, 4'sh0, seq_pkg::C_EALO,
				c == seq_pkg::CL_EXT_JUMP);
		end else begin
			case (c)
				seq_pkg::CL_IDX_STA: begin
					case (n)
						4'h3:    m = nv(seq_pkg::A_X, 4'sh0, 1'b0);
						4'h4:    m = nv(seq_pkg::A_XNC, 4'sh0, 1'b0);
						4'h5:    m = nv(seq_pkg::A_XOFF, 4'sh0, 1'b0);
						default: m = wr(seq_pkg::A_XOFF, 4'sh0,
							seq_pkg::D_ACC, 1'b1);
					endcase
				end
				seq_pkg::CL_IDX_RMW, seq_pkg::CL_IDX_TST: begin
					case (n)
						4'h3:    m = nv(seq_pkg::A_X, 4'sh0, 1'b0);
						4'h4:    m = nv(seq_pkg::A_XNC, 4'sh0, 1'b0);
						4'h5:    m = rd(seq_pkg::A_XOFF, 4'sh0,
							seq_pkg::C_DLO, 1'b0);
						4'h6:    m = nv(seq_pkg::A_XOFF, 4'sh0, 1'b0);
						default: m = wr(seq_pkg::A_XOFF, 4'sh0,
							seq_pkg::D_NEW, 1'b1);
					endcase
				end
				seq_pkg::CL_IDX_ST16: begin
					case (n)
						4'h3:    m = nv(seq_pkg::A_X, 4'sh0, 1'b0);
						4'h4:    m = nv(seq_pkg::A_XNC, 4'sh0, 1'b0);
						4'h5:    m = nv(seq_pkg::A_XOFF, 4'sh0, 1'b0);
						4'h6:    m = wr(seq_pkg::A_XOFF, 4'sh0,
							seq_pkg::D_WHI, 1'b0);
						default: m = wr(seq_pkg::A_XOFF1, 4'sh0,
							seq_pkg::D_WLO, 1'b1);
					endcase
				end
				seq_pkg::CL_IDX_CALL: begin
					case (n)
						4'h3:    m = nv(seq_pkg::A_X, 4'sh0, 1'b0);
						4'h4:    m = wr(seq_pkg::A_SP, 4'sh0,
							seq_pkg::D_RLO, 1'b0);
						4'h5:    m = wr(seq_pkg::A_SP, -4'sh1,
							seq_pkg::D_RHI, 1'b0);
						4'h6:    m = nv(seq_pkg::A_SP, -4'sh2, 1'b0);
						4'h7:    m = nv(seq_pkg::A_X, 4'sh0, 1'b0);
						default: m = nv(seq_pkg::A_XNC, 4'sh0, 1'b1);
					endcase
				end
				seq_pkg::CL_EXT_RD8:
					m = rd(seq_pkg::A_EA, 4'sh0, seq_pkg::C_DLO, 1'b1);
				seq_pkg::CL_EXT_RD16: begin
					if (n == 4'h4)
						m = rd(seq_pkg::A_EA, 4'sh0, seq_pkg::C_DHI, 1'b0);
					else
						m = rd(seq_pkg::A_EA1, 4'sh0, seq_pkg::C_DLO, 1'b1);
				end
				seq_pkg::CL_EXT_STA: begin
					if (n == 4'h4)
						m = nv(seq_pkg::A_EA, 4'sh0, 1'b0);
					else
						m = wr(seq_pkg::A_EA, 4'sh0, seq_pkg::D_ACC, 1'b1);
				end
				seq_pkg::CL_EXT_RMW, seq_pkg::CL_EXT_TST: begin
					case (n)
						4'h4:    m = rd(seq_pkg::A_EA, 4'sh0,
							seq_pkg::C_DLO, 1'b0);
						4'h5:    m = nv(seq_pkg::A_EA, 4'sh0, 1'b0);
						default: m = wr(seq_pkg::A_EA, 4'sh0,
							seq_pkg::D_NEW, 1'b1);
					endcase
				end
				seq_pkg::CL_EXT_ST16: begin
					case (n)
						4'h4:    m = nv(seq_pkg::A_EA, 4'sh0, 1'b0);
						4'h5:    m = wr(seq_pkg::A_EA, 4'sh0,
							seq_pkg::D_WHI, 1'b0);
						default: m = wr(seq_pkg::A_EA1, 4'sh0,
							seq_pkg::D_WLO, 1'b1);
					endcase
				end
				seq_pkg::CL_EXT_CALL: begin
					case (n)
						4'h4:    m = rd(seq_pkg::A_EA, 4'sh0,
							seq_pkg::C_NONE, 1'b0);
						4'h5:    m = wr(seq_pkg::A_SP, 4'sh0,
							seq_pkg::D_RLO, 1'b0);
						4'h6:    m = wr(seq_pkg::A_SP, -4'sh1,
							seq_pkg::D_RHI, 1'b0);
						4'h7:    m = nv(seq_pkg::A_SP, -4'sh2, 1'b0);
						4'h8:    m = nv(seq_pkg::A_PC2, 4'sh0, 1'b0);
						default: m = rd(seq_pkg::A_PC2, 4'sh0,
							seq_pkg::C_NONE, 1'b1);
					endcase
				end
				seq_pkg::CL_PUSH: begin
					if (n == 4'h3)
						m = wr(seq_pkg::A_SP, 4'sh0, seq_pkg::D_ACC, 1'b0);
					else
						m = nv(seq_pkg::A_SP, -4'sh1, 1'b1);
				end
				seq_pkg::CL_PULL: begin
					if (n == 4'h3)
						m = nv(seq_pkg::A_SP, 4'sh0, 1'b0);
					else
						m = rd(seq_pkg::A_SP, 4'sh1, seq_pkg::C_DLO, 1'b1);
				end
				seq_pkg::CL_RETURN: begin
					case (n)
						4'h3:    m = nv(seq_pkg::A_SP, 4'sh0, 1'b0);
						4'h4:    m = rd(seq_pkg::A_SP, 4'sh1,
							seq_pkg::C_DHI, 1'b0);
						default: m = rd(seq_pkg::A_SP, 4'sh2,
							seq_pkg::C_DLO, 1'b1);
					endcase
				end
				seq_pkg::CL_WAIT, seq_pkg::CL_TRAP: begin
					// Stacking order follows the encoding of D_RLO..D_CC
					if (n <= 4'h9)
						m = wr(seq_pkg::A_SP, 4'($signed(4'h3 - n)),
							seq_pkg::dat_src_t'(n - 4'h2),
							(n == 4'h9) && (c == seq_pkg::CL_WAIT));
					else if (n == 4'hA)
						m = nv(seq_pkg::A_SP, -4'sh7, 1'b0);
					else if (n == 4'hB)
						m = rd(seq_pkg::A_VHI, 4'sh0, seq_pkg::C_DHI, 1'b0);
					else
						m = rd(seq_pkg::A_VLO, 4'sh0, seq_pkg::C_DLO, 1'b1);
				end
				seq_pkg::CL_IRET: begin
					if (n == 4'h3)
						m = nv(seq_pkg::A_SP, 4'sh0, 1'b0);
					else
						m = rd(seq_pkg::A_SP, 4'(n - 4'h3),
							(n == 4'h9) ? seq_pkg::C_DHI :
							(n == 4'hA) ? seq_pkg::C_DLO : seq_pkg::C_NONE,
							n == 4'hA);
				end
				seq_pkg::CL_BRANCH: begin
					if (n == 4'h3)
						m = nv(seq_pkg::A_PC2, 4'sh0, 1'b0);
					else
						m = nv(seq_pkg::A_BTGT, 4'sh0, 1'b1);
				end
				seq_pkg::CL_BRSUB: begin
					case (n)
						4'h3:    m = nv(seq_pkg::A_PC2, 4'sh0, 1'b0);
						4'h4:    m = wr(seq_pkg::A_SP, 4'sh0,
							seq_pkg::D_RLO, 1'b0);
						4'h5:    m = wr(seq_pkg::A_SP, -4'sh1,
							seq_pkg::D_RHI, 1'b0);
						4'h6:    m = nv(seq_pkg::A_SP, -4'sh2, 1'b0);
						4'h7:    m = nv(seq_pkg::A_PC2, 4'sh0, 1'b0);
						default: m = nv(seq_pkg::A_MIX, 4'sh0, 1'b1);
					endcase
				end
				default: m = nv(seq_pkg::A_PC, 4'sh0, 1'b1);
			endcase
		end
		// Test writes nothing: strobe stays low and the bus stays free
		if ((c == seq_pkg::CL_IDX_TST || c == seq_pkg::CL_EXT_TST) &&
			m.last)
			m.valid_address_strobe = 1'b0;
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////
	// State

	seq_pkg::st_t               st_r;
	seq_pkg::cls_t              cls_r;
	seq_pkg::micro_t            cur_r;
	seq_pkg::micro_t            nxt;
	logic [`SEQ_STEP_W-1:0]     step_r;
	logic [`SEQ_STEP_W-1:0]     step_nxt;
	logic                       take;
	logic [15:0]                pc_r;
	logic [15:0]                sp_r;
	logic [15:0]                x_r;
	logic [15:0]                ret_r;
	logic [15:0]                wsrc_r;
	logic [7:0]                 a_r;
	logic [7:0]                 b_r;
	logic [7:0]                 cc_r;
	logic [7:0]                 new_r;
	logic                       use_b_r;
	logic [7:0]                 off_r;
	logic [15:0]                ea_r;
	logic [15:0]                ret_nxt;

	seq_if s ();

	seq_addr_gen u_addr (
		.s (s)
	);

	seq_data_sel u_data (
		.s (s)
	);

	assign take     = (st_r == seq_pkg::ST_IDLE) && start_i;
	assign step_nxt = take ? `SEQ_STEP_FIRST : step_r + 4'h1;
	assign nxt      = micro(take ? class_i : cls_r, step_nxt);

	always_comb begin
		case (class_i)
			seq_pkg::CL_IDX_CALL: ret_nxt = pc_i + `SEQ_RET_CALL_X;
			seq_pkg::CL_EXT_CALL: ret_nxt = pc_i + `SEQ_RET_CALL_E;
			seq_pkg::CL_BRSUB:    ret_nxt = pc_i + `SEQ_RET_BRSUB;
			default:              ret_nxt = pc_i + `SEQ_RET_STACK;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Interface drive

	// First step needs the op code address before it is latched
	assign s.pc     = (st_r == seq_pkg::ST_IDLE) ? pc_i : pc_r;
	assign s.sp     = sp_r;
	assign s.x      = x_r;
	assign s.off    = off_r;
	// Low address byte arrives in the cycle just before its first use
	assign s.ea     = (st_r == seq_pkg::ST_RUN &&
		cur_r.cap == seq_pkg::C_EALO) ? {ea_r[15:8], data_i} : ea_r;
	assign s.asrc   = nxt.asrc;
	assign s.dsp    = nxt.dsp;
	assign s.dsrc   = nxt.dsrc;
	assign s.ret    = ret_r;
	assign s.acc_a  = a_r;
	assign s.acc_b  = b_r;
	assign s.use_b  = use_b_r;
	assign s.cc     = cc_r;
	assign s.word   = wsrc_r;
	assign s.new_op = new_r;

	////////////////////////////////////////////////////////////////////
	// Sequencing

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			st_r   <= seq_pkg::ST_IDLE;
			step_r <= `SEQ_STEP_FIRST;
			cls_r  <= seq_pkg::CL_INH;
			cur_r  <= '0;
		end else begin
			case (st_r)
				seq_pkg::ST_IDLE: begin
					if (start_i) begin
						st_r   <= seq_pkg::ST_RUN;
						step_r <= step_nxt;
						cls_r  <= class_i;
						cur_r  <= nxt;
					end
				end
				seq_pkg::ST_RUN: begin
					if (cur_r.last) begin
						st_r  <= seq_pkg::ST_IDLE;
						cur_r <= '0;
					end else begin
						step_r <= step_nxt;
						cur_r  <= nxt;
					end
				end
				default: st_r <= seq_pkg::ST_IDLE;
			endcase
		end
	end

	// Snapshot taken once so the caller may change its registers freely
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			pc_r    <= `SEQ_ADDR_RST;
			sp_r    <= `SEQ_ADDR_RST;
			x_r     <= `SEQ_ADDR_RST;
			ret_r   <= `SEQ_ADDR_RST;
			wsrc_r  <= `SEQ_WORD_RST;
			a_r     <= `SEQ_DATA_RST;
			b_r     <= `SEQ_DATA_RST;
			cc_r    <= `SEQ_DATA_RST;
			new_r   <= `SEQ_DATA_RST;
			use_b_r <= 1'b0;
		end else if (take) begin
			pc_r    <= pc_i;
			sp_r    <= sp_i;
			x_r     <= x_i;
			ret_r   <= ret_nxt;
			wsrc_r  <= word_i;
			a_r     <= acc_a_i;
			b_r     <= acc_b_i;
			cc_r    <= cc_i;
			new_r   <= new_i;
			use_b_r <= use_b_i;
		end
	end

	// Read data is taken at the end of the cycle that presented it
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			off_r  <= `SEQ_DATA_RST;
			ea_r   <= `SEQ_WORD_RST;
			word_o <= `SEQ_WORD_RST;
		end else if (st_r == seq_pkg::ST_RUN) begin
			case (cur_r.cap)
				seq_pkg::C_OFF:  off_r        <= data_i;
				seq_pkg::C_EAHI: ea_r[15:8]   <= data_i;
				seq_pkg::C_EALO: ea_r[7:0]    <= data_i;
				seq_pkg::C_DHI:  word_o[15:8] <= data_i;
				seq_pkg::C_DLO:  word_o[7:0]  <= data_i;
				default:         off_r        <= off_r;
			endcase
		end
	end

	assign target_o = ea_r;

	////////////////////////////////////////////////////////////////////
	// Bus outputs

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			addr_o      <= `SEQ_ADDR_RST;
			vma_o       <= 1'b0;
			rw_o        <= 1'b1;
			data_o      <= `SEQ_DATA_RST;
			data_oe_n_o <= 1'b1;
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
		end else if (take || (st_r == seq_pkg::ST_RUN && !cur_r.last)) begin
			addr_o      <= s.addr;
			vma_o       <= nxt.valid_address_strobe;
			rw_o        <= nxt.rw;
			data_o      <= s.wdata;
			data_oe_n_o <= nxt.rw || !nxt.valid_address_strobe;
			busy_o      <= 1'b1;
			done_o      <= nxt.last;
		end else begin
			vma_o       <= 1'b0;
			rw_o        <= 1'b1;
			data_oe_n_o <= 1'b1;
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// File: cpu_bus_cycle_sequencer_props.sv
`default_nettype none

module cpu_bus_cycle_sequencer_props (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          reset_n_i,
	// Request
	input  wire logic          start_i,
	input  wire seq_pkg::cls_t class_i,
	input  wire logic [15:0]   pc_i,
	// Bus and status
	input  wire logic [15:0]   addr_o,
	input  wire logic          vma_o,
	input  wire logic          rw_o,
	input  wire logic          data_oe_n_o,
	input  wire logic          busy_o,
	input  wire logic          done_o
);
	logic [15:0] pc_r;

	always_ff @(posedge clk_i) begin
		if (start_i && !busy_o) begin
			pc_r <= pc_i;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence take(seq_pkg::cls_t c);
		start_i && !busy_o && class_i == c;
	endsequence
	sequence push_pair;
		(vma_o && !rw_o) [*2];
	endsequence
	sequence vec_pair;
		(addr_o == 16'hFFFA && vma_o && rw_o) ##1
		(addr_o == 16'hFFFB && vma_o && rw_o && done_o);
	endsequence

	idle_after_done_a: assert property (done_o |=> !busy_o && !vma_o && rw_o)
		else $error("no idle cycle after the last bus cycle");
	drive_only_write_a: assert property (!data_oe_n_o |-> vma_o && !rw_o)
		else $error("data bus driven outside a write cycle");
	strobe_in_busy_a: assert property (vma_o |-> busy_o)
		else $error("strobe high outside an instruction");
	sta_index_a: assert property (take(seq_pkg::CL_IDX_STA) |-> ##3
		(!vma_o) [*3] ##1 (vma_o && !rw_o && done_o && !data_oe_n_o))
		else $error("indexed store sequence wrong");
	tst_quiet_a: assert property (take(seq_pkg::CL_EXT_TST) |->
		##6 (done_o && !vma_o && data_oe_n_o))
		else $error("test operand touched memory");
	wait_length_a: assert property (take(seq_pkg::CL_WAIT) |->
		##3 (vma_o && !rw_o) [*7] ##0 done_o)
		else $error("wait stacking sequence wrong");
	trap_vector_a: assert property (take(seq_pkg::CL_TRAP) |->
		##10 !vma_o ##1 vec_pair)
		else $error("trap vector fetch wrong");
	iret_reads_a: assert property (take(seq_pkg::CL_IRET) |->
		##3 !vma_o ##1 (vma_o && rw_o) [*7] ##0 done_o)
		else $error("interrupt return reads wrong");
	brsub_last_a: assert property (take(seq_pkg::CL_BRSUB) |->
		##4 push_pair ##1 (!vma_o) [*3] ##0
		(done_o && addr_o[15:8] == pc_r[15:8]))
		else $error("branch call tail wrong");
	return_discard_a: assert property (take(seq_pkg::CL_RETURN) |->
		##2 (vma_o && rw_o && addr_o == pc_r + 16'h0001) ##1 !vma_o)
		else $error("return second cycle wrong");
endmodule

bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_props props_inst (
	.clk_i, .reset_n_i, .start_i, .class_i, .pc_i, .addr_o, .vma_o,
	.rw_o, .data_oe_n_o, .busy_o, .done_o
);

`default_nettype wire

// File: cpu_bus_cycle_sequencer_tb.sv
`default_nettype none

module cpu_bus_cycle_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic          clk_i = 1'b0;
	logic          reset_n_i = 1'b0;
	logic          start_i = 1'b0;
	seq_pkg::cls_t class_i = seq_pkg::CL_INH;
	logic          use_b_i = 1'b0;
	logic [15:0]   pc_i = '0, sp_i = '0, x_i = '0, word_i = '0;
	logic [7:0]    acc_a_i = '0, acc_b_i = '0, cc_i = '0, new_i = '0;
	logic [7:0]    data_i, data_o;
	logic [15:0]   addr_o, word_o, target_o;
	logic          vma_o, rw_o, data_oe_n_o, busy_o, done_o;
	int            mismatches = 0;
	int            tests_run = 0;
	logic [27:0]   q[$];

	cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_inst (
		.clk_i, .reset_n_i, .start_i, .class_i, .use_b_i, .pc_i, .sp_i,
		.x_i, .acc_a_i, .acc_b_i, .cc_i, .word_i, .new_i(new_i), .data_i,
		.addr_o, .vma_o, .rw_o, .data_o, .data_oe_n_o, .busy_o, .done_o,
		.word_o, .target_o
	);

	seq_bus_mem seq_bus_mem_inst (
		.clk_i, .addr_i(addr_o), .vma_i(vma_o), .rw_i(rw_o), .data_o(data_i)
	);

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	function automatic logic [7:0] f(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h5A;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Negative address or data means the cycle's value is not checked
	task automatic p(input logic v, w, input int a = -1, d = -1);
		q.push_back({v, w, a >= 0, d >= 0, a[15:0], d[7:0]});
	endtask

	task automatic run(input seq_pkg::cls_t c);
		logic [15:0] ea, r, t, ew, m, xn;
		logic [7:0]  ac, off;
		logic [7:0]  st [7];
		logic [27:0] e;
		logic        ckw, ext;
		int          n;
		@(posedge clk_i);
		start_i <= 1'b1;
		class_i <= c;
		use_b_i <= 1'($urandom);
		pc_i <= 16'($urandom);
		sp_i <= 16'($urandom_range(16'hFFF0, 16'h0010));
		x_i <= 16'($urandom);
		word_i <= 16'($urandom);
		{acc_a_i, acc_b_i, cc_i, new_i} <= $urandom;
		@(posedge clk_i);
		off = f(pc_i + 16'h0001);
		ea = {off, f(pc_i + 16'h0002)};
		t = pc_i + 16'h0002 + {{8{off[7]}}, off};
		ac = use_b_i ? acc_b_i : acc_a_i;
		ext = c >= seq_pkg::CL_EXT_JUMP && c <= seq_pkg::CL_EXT_CALL;
		m = ext ? ea : x_i + off;
		xn = {x_i[15:8], 8'(x_i[7:0] + off)};
		ckw = 1'b0;
		q = {};
		p(1, 1, pc_i);
		p(1, 1, pc_i + 1);
		if (ext) begin
			p(1, 1, pc_i + 2);
		end
		// Indexed data classes idle at X, then at X plus offset without carry
		if (c < seq_pkg::CL_IDX_CALL) begin
			p(0, 1, x_i);
			p(0, 1, xn);
		end
		case (c)
			seq_pkg::CL_IDX_CALL, seq_pkg::CL_EXT_CALL, seq_pkg::CL_BRSUB: begin
				r = pc_i + ((c == seq_pkg::CL_EXT_CALL) ? 16'h0003 : 16'h0002);
				if (c == seq_pkg::CL_IDX_CALL) p(0, 1, x_i);
				if (c == seq_pkg::CL_EXT_CALL) p(1, 1, ea);
				if (c == seq_pkg::CL_BRSUB) p(0, 1, r);
				p(1, 0, sp_i, r[7:0]); p(1, 0, sp_i - 1, r[15:8]); p(0, 1, sp_i - 2);
				if (c == seq_pkg::CL_IDX_CALL) begin
					p(0, 1, x_i); p(0, 1, xn);
				end else if (c == seq_pkg::CL_EXT_CALL) begin
					p(0, 1, pc_i + 2); p(1, 1, pc_i + 2);
				end else begin
					p(0, 1, r); p(0, 1, {pc_i[15:8], t[7:0]});
				end
			end
			seq_pkg::CL_EXT_RD8: p(1, 1, ea);
			seq_pkg::CL_EXT_RD16: begin
				p(1, 1, ea); p(1, 1, ea + 1);
				ew = {f(ea), f(ea + 16'h0001)}; ckw = 1'b1;
			end
			seq_pkg::CL_IDX_STA, seq_pkg::CL_EXT_STA: begin
				p(0, 1, m);
				p(1, 0, m, ac);
			end
			seq_pkg::CL_IDX_RMW, seq_pkg::CL_EXT_RMW: begin
				p(1, 1, m);
				p(0, 1, m);
				p(1, 0, m, new_i);
			end
			seq_pkg::CL_IDX_TST, seq_pkg::CL_EXT_TST: begin
				p(1, 1, m);
				p(0, 1, m);
				p(0, 0, m);
			end
			seq_pkg::CL_IDX_ST16, seq_pkg::CL_EXT_ST16: begin
				p(0, 1, m);
				p(1, 0, m, word_i[15:8]);
				p(1, 0, m + 1, word_i[7:0]);
			end
			seq_pkg::CL_PUSH: begin
				p(1, 0, sp_i, ac); p(0, 1, sp_i - 1);
			end
			seq_pkg::CL_PULL: begin
				p(0, 1, sp_i); p(1, 1, sp_i + 1);
			end
			seq_pkg::CL_RETURN, seq_pkg::CL_IRET: begin
				p(0, 1, sp_i);
				for (n = 1; n <= ((c == seq_pkg::CL_IRET) ? 7 : 2); n++) p(1, 1, sp_i + n);
				ew = {f(q[q.size()-2][23:8]), f(q[q.size()-1][23:8])}; ckw = 1'b1;
			end
			seq_pkg::CL_WAIT, seq_pkg::CL_TRAP: begin
				r = pc_i + 16'h0001;
				st = '{r[7:0], r[15:8], x_i[7:0], x_i[15:8], acc_a_i, acc_b_i, cc_i};
				for (n = 0; n < 7; n++) p(1, 0, sp_i - n, st[n]);
				if (c == seq_pkg::CL_TRAP) begin
					p(0, 1, sp_i - 7); p(1, 1, 'hFFFA); p(1, 1, 'hFFFB);
					ew = {f(16'hFFFA), f(16'hFFFB)}; ckw = 1'b1;
				end
			end
			seq_pkg::CL_BRANCH: begin
				p(0, 1, pc_i + 2); p(0, 1, t);
			end
			default: ;
		endcase
		for (n = 0; n < q.size(); n++) begin
			@(negedge clk_i);
			e = q[n];
			chk("vma", e[27], vma_o);
			chk("rw", e[26], rw_o);
			chk("busy", 1'b1, busy_o);
			chk("done", n == q.size() - 1, done_o);
			chk("oe_n", !e[24], data_oe_n_o);
			if (e[25]) chk("addr", e[23:8], addr_o);
			if (e[24]) chk("data", e[7:0], data_o);
			if (n == 0) begin
				@(posedge clk_i);
				start_i <= 1'b0;
			end
		end
		@(negedge clk_i);
		chk("idle", 2'b00, {busy_o, vma_o});
		if (ckw) chk("word", ew, word_o);
		if (ext) chk("target", ea, target_o);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		stop_test;
	end

	initial begin
		void'($urandom(36));
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk("reset", 5'b01001, {vma_o, rw_o, busy_o, done_o, data_oe_n_o});
		@(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int k = 0; k < 80; k++) begin
			// Every class once in encoding order, then at random
			run(seq_pkg::cls_t'(5'((k < 22) ? k : $urandom % 22)));
		end
		stop_test;
	end
endmodule

`default_nettype wire

// File: seq_addr_gen.sv
`include "seq_cfg.svh"
`default_nettype none

module seq_addr_gen (
	seq_if.addr_mp s
);
	logic [15:0] sp_adj;
	logic [15:0] x_off;
	logic [15:0] btgt;

	assign sp_adj = s.sp + {{12{s.dsp[3]}}, s.dsp};
	assign x_off  = s.x + {8'h00, s.off};
	assign btgt   = s.pc + 16'h0002 + {{8{s.off[7]}}, s.off};

	always_comb begin
		case (s.asrc)
			seq_pkg::A_PC:    s.addr = s.pc;
			seq_pkg::A_PC1:   s.addr = s.pc + 16'h0001;
			seq_pkg::A_PC2:   s.addr = s.pc + 16'h0002;
			seq_pkg::A_X:     s.addr = s.x;
			// Low byte sum only: the carry has not reached the high half
			seq_pkg::A_XNC:   s.addr = {s.x[15:8], s.x[7:0] + s.off};
			seq_pkg::A_XOFF:  s.addr = x_off;
			seq_pkg::A_XOFF1: s.addr = x_off + 16'h0001;
			seq_pkg::A_EA:    s.addr = s.ea;
			seq_pkg::A_EA1:   s.addr = s.ea + 16'h0001;
			seq_pkg::A_SP:    s.addr = sp_adj;
			seq_pkg::A_VHI:   s.addr = `SEQ_VEC_HI;
			seq_pkg::A_VLO:   s.addr = `SEQ_VEC_LO;
			seq_pkg::A_BTGT:  s.addr = btgt;
			seq_pkg::A_MIX:   s.addr = {s.pc[15:8], btgt[7:0]};
			default:          s.addr = s.pc;
		endcase
	end
endmodule

`default_nettype wire

// File: seq_bus_mem.sv
`default_nettype none

module seq_bus_mem (
	// Clock
	input  wire logic        clk_i,
	// Bus from the sequencer
	input  wire logic [15:0] addr_i,
	input  wire logic        vma_i,
	input  wire logic        rw_i,
	// Read data back to the sequencer
	output logic      [7:0]  data_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] last_r;

	// A floating bus must not look like a held byte, so flip it each cycle
	always_comb begin
		if (vma_i && rw_i) begin
			data_o = addr_i[15:8] ^ addr_i[7:0] ^ 8'h5A;
		end else begin
			data_o = ~last_r;
		end
	end

	always_ff @(posedge clk_i) begin
		last_r <= data_o;
	end
endmodule

`default_nettype wire

// File: seq_cfg.svh
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// Vector pair read by the software trap
`define SEQ_VEC_HI      16'hFFFA
`define SEQ_VEC_LO      16'hFFFB

// Step counter width and first step
`define SEQ_STEP_W      4
`define SEQ_STEP_FIRST  4'h1

// Return address distance from the op code address
`define SEQ_RET_CALL_X  16'h0002
`define SEQ_RET_CALL_E  16'h0003
`define SEQ_RET_BRSUB   16'h0002
`define SEQ_RET_STACK   16'h0001

// Reset values of the outputs and held registers
`define SEQ_ADDR_RST    16'h0000
`define SEQ_DATA_RST    8'h00
`define SEQ_WORD_RST    16'h0000

`endif

// File: seq_data_sel.sv
`default_nettype none

module seq_data_sel (
	seq_if.data_mp s
);
	always_comb begin
		case (s.dsrc)
			seq_pkg::D_RLO: s.wdata = s.ret[7:0];
			seq_pkg::D_RHI: s.wdata = s.ret[15:8];
			seq_pkg::D_XLO: s.wdata = s.x[7:0];
			seq_pkg::D_XHI: s.wdata = s.x[15:8];
			seq_pkg::D_A:   s.wdata = s.acc_a;
			seq_pkg::D_B:   s.wdata = s.acc_b;
			seq_pkg::D_CC:  s.wdata = s.cc;
			seq_pkg::D_ACC: s.wdata = s.use_b ? s.acc_b : s.acc_a;
			seq_pkg::D_WHI: s.wdata = s.word[15:8];
			seq_pkg::D_WLO: s.wdata = s.word[7:0];
			seq_pkg::D_NEW: s.wdata = s.new_op;
			default:        s.wdata = 8'h00;
		endcase
	end
endmodule

`default_nettype wire

// File: seq_if.sv
`default_nettype none

interface seq_if;
	seq_pkg::addr_src_t asrc;
	logic signed [3:0]  dsp;
	seq_pkg::dat_src_t  dsrc;
	logic [15:0]        pc;
	logic [15:0]        sp;
	logic [15:0]        x;
	logic [15:0]        ea;
	logic [7:0]         off;
	logic [15:0]        ret;
	logic [7:0]         acc_a;
	logic [7:0]         acc_b;
	logic               use_b;
	logic [7:0]         cc;
	logic [15:0]        word;
	logic [7:0]         new_op;
	logic [15:0]        addr;
	logic [7:0]         wdata;

	modport addr_mp (
		input  asrc, dsp, pc, sp, x, ea, off,
		output addr
	);

	modport data_mp (
		input  dsrc, ret, x, acc_a, acc_b, use_b, cc, word, new_op,
		output wdata
	);

	modport ctl_mp (
		output asrc, dsp, dsrc, pc, sp, x, ea, off, ret,
		output acc_a, acc_b, use_b, cc, word, new_op,
		input  addr, wdata
	);
endinterface

`default_nettype wire

// File: seq_pkg.sv
`default_nettype none

package seq_pkg;

	typedef enum logic [4:0] {
		CL_IDX_STA  = 5'h00,
		CL_IDX_RMW  = 5'h01,
		CL_IDX_TST  = 5'h02,
		CL_IDX_ST16 = 5'h03,
		CL_IDX_CALL = 5'h04,
		CL_EXT_JUMP = 5'h05,
		CL_EXT_RD8  = 5'h06,
		CL_EXT_RD16 = 5'h07,
		CL_EXT_STA  = 5'h08,
		CL_EXT_RMW  = 5'h09,
		CL_EXT_TST  = 5'h0A,
		CL_EXT_ST16 = 5'h0B,
		CL_EXT_CALL = 5'h0C,
		CL_INH      = 5'h0D,
		CL_PUSH     = 5'h0E,
		CL_PULL     = 5'h0F,
		CL_RETURN   = 5'h10,
		CL_WAIT     = 5'h11,
		CL_TRAP     = 5'h12,
		CL_IRET     = 5'h13,
		CL_BRANCH   = 5'h14,
		CL_BRSUB    = 5'h15
	} cls_t;

	typedef enum logic [3:0] {
		A_PC = 4'h0, A_PC1 = 4'h1, A_PC2 = 4'h2, A_X = 4'h3,
		A_XNC = 4'h4, A_XOFF = 4'h5, A_XOFF1 = 4'h6, A_EA = 4'h7,
		A_EA1 = 4'h8, A_SP = 4'h9, A_VHI = 4'hA, A_VLO = 4'hB,
		A_BTGT = 4'hC, A_MIX = 4'hD
	} addr_src_t;

	typedef enum logic [3:0] {
		D_NONE = 4'h0, D_RLO = 4'h1, D_RHI = 4'h2, D_XLO = 4'h3,
		D_XHI = 4'h4, D_A = 4'h5, D_B = 4'h6, D_CC = 4'h7,
		D_ACC = 4'h8, D_WHI = 4'h9, D_WLO = 4'hA, D_NEW = 4'hB
	} dat_src_t;

	typedef enum logic [2:0] {
		C_NONE = 3'h0, C_OFF = 3'h1, C_EAHI = 3'h2, C_EALO = 3'h3,
		C_DHI = 3'h4, C_DLO = 3'h5
	} cap_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} st_t;

	typedef struct packed {
		logic              valid_address_strobe;
		logic              rw;
		addr_src_t         asrc;
		logic signed [3:0] dsp;
		dat_src_t          dsrc;
		cap_t              cap;
		logic              last;
	} micro_t;

endpackage

`default_nettype wire
